/* aspt_pkg.sv */
// shared constants for the serial port and its far-end node
package aspt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h98;   // serial_port_control
  localparam logic [7:0] DATA_IDX = 8'h99;   // serial_data_buffer
  localparam logic [7:0] RELOAD_IDX = 8'h9A; // timer_reload_value
  localparam logic [7:0] TCTRL_IDX = 8'h9B;  // timer control: enable, irq enable, clock select

  // serial_port_control layout and reset value
  localparam int FRAME_BIT = 7;  // frame_width_select
  localparam int UNUSED_BIT = 6; // reads as one
  localparam int QUAL_BIT = 5;   // receive_qualifier_enable
  localparam int RXEN_BIT = 4;   // receiver_enable
  localparam int TX9_BIT = 3;    // transmit_ninth_bit
  localparam int RX9_BIT = 2;    // received_ninth_bit
  localparam int TXDONE_BIT = 1; // transmit_complete_flag
  localparam int RXDONE_BIT = 0; // receive_complete_flag
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // timer control layout and reset values
  localparam int TMR_EN_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int CLKSEL_LSB = 4; // three-bit field [6:4]
  localparam logic [7:0] TCTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;

  // timer clock source encodings
  localparam logic [2:0] CLK_SYS = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h1;
  localparam logic [2:0] CLK_DIV12 = 3'h2;
  localparam logic [2:0] CLK_DIV48 = 3'h3;
  localparam logic [2:0] CLK_EXT8 = 3'h4;

  // divider ratios
  localparam int DIV4 = 4;
  localparam int DIV12 = 12;
  localparam int DIV48 = 48;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7; // external clock divided by 8

  localparam logic [7:0] TMR_TOP = 8'hFF; // 8-bit timer overflows past this
  localparam logic [3:0] FRAME_BITS_8 = 4'hA; // start, 8 data, stop
  localparam logic [3:0] FRAME_BITS_9 = 4'hB; // start, 8 data, ninth, stop

  // far-end node bit time in clocks (reload 0xF3 at system clock gives 26)
  localparam int NODE_CLKS_PER_BIT = 26;

endpackage

/* aspt_link_if.sv */
// serial line pair between the port and the far-end node
`timescale 1ns/1ps
interface aspt_link_if;
  logic portToNode; // port transmit line, idle high
  logic nodeToPort; // node transmit line, idle high
  modport port (output portToNode, input nodeToPort);
  modport node (input portToNode, output nodeToPort);
endinterface

/* aspt_port.sv */
// asynchronous serial port with timer-driven baud generator and avalon-mm registers
`timescale 1ns/1ps

// Overview of operation
// [RL1] tx bit clock from 8-bit reload timer
// [RL2] hidden rx timer shares enable and reload
// [RL3] overflows halved: rate = clk/(256-reload)/2
// [RL4] start detection forces rx timer reload
// [RL5] timer clock: sys, /4, /12, /48, ext/8
// [RL6] control bit 7 selects 8 or 9 bits
// [RL7] 8-bit frame: start, 8 data lsb first, stop
// [RL8] 9-bit frame adds transmit ninth bit before stop
// [RL9] data buffer write starts a transmission
// [RL10] transmit flag set at stop bit start
// [RL11] receive only while receiver enable set
// [RL12] 8-bit load: flag clear, stop ok if qualified
// [RL13] 9-bit load: flag clear, ninth set if qualified
// [RL14] failed load leaves buffer, bit, flag alone
// [RL15] overrun keeps first byte, drops later one
// [RL16] interrupt request when either flag set
// [RL17] only software clears the two flags
// [RL18] receive flag set when stop sampled
// [RL19] control bit 6 reads one, ignores writes
// [RL20] master sends address with ninth bit one
// [RL21] slave software toggles qualifier around message
// [RL22] data read gives receive latch, write transmits
// [RL23] start is falling edge on idle line
module aspt_port
  import aspt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce, // freezes all state when low
  input wire logic extOscClk, // external oscillator, foreign domain
  input wire logic [9:0] address, // avalon byte address
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq, // level, high while enabled flag is set
  aspt_link_if.port link
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  logic busAck; // second cycle of every access
  logic [7:0] wordIdx;
  logic wrStrobe;
  logic frame9, qual, rxEn, tx9, rx9, txDone, rxDone;
  logic [7:0] reloadVal; // timer_reload_value
  logic tmrEn, irqEn;
  logic [2:0] clkSel;
  logic [7:0] rxBuf; // receive latch
  logic [7:0] ctrlRead;

  assign wordIdx = address[9:2];
  // one wait cycle per access, so the register write sees stable data
  assign waitrequest = (read || write) && !busAck;
  assign wrStrobe = write && busAck && ce;

  // ack toggles high for one cycle after any request
  always_ff @(posedge clk) begin
    if (rst) begin
      busAck <= 1'b0;
    end else if (ce) begin
      busAck <= (read || write) && !busAck;
    end
  end

  // [RL19] bit six forced to one
  assign ctrlRead = {frame9, 1'b1, qual, rxEn, tx9, rx9, txDone, rxDone};

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && !busAck) begin
      unique case (wordIdx)
        CTRL_IDX: readdata <= {24'h00_0000, ctrlRead};
        // [RL22] read returns receive latch
        DATA_IDX: readdata <= {24'h00_0000, rxBuf};
        RELOAD_IDX: readdata <= {24'h00_0000, reloadVal};
        TCTRL_IDX: readdata <= {24'h00_0000, 1'b0, clkSel, 2'b00, irqEn, tmrEn};
        default: readdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // timer configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      reloadVal <= RELOAD_RESET;
      tmrEn <= TCTRL_RESET[TMR_EN_BIT];
      irqEn <= TCTRL_RESET[IRQ_EN_BIT];
      clkSel <= TCTRL_RESET[CLKSEL_LSB +: 3];
    end else if (wrStrobe && wordIdx == RELOAD_IDX) begin
      reloadVal <= writedata[7:0];
    end else if (wrStrobe && wordIdx == TCTRL_IDX) begin
      tmrEn <= writedata[TMR_EN_BIT];
      irqEn <= writedata[IRQ_EN_BIT];
      clkSel <= writedata[CLKSEL_LSB +: 3];
    end
  end

  // [RL16] interrupt from either flag when enabled
  assign irq = irqEn && (txDone || rxDone);

  ////////////////////////////////////////////////////////////////////////
  // timer clock sources
  localparam int DIVS [3] = '{DIV4, DIV12, DIV48};
  logic [2:0] divTick;
  logic extS1, extS2, extPrev; // external clock synchroniser and edge memory
  logic [2:0] extCnt;
  logic extTick;
  logic tmrTick;

  // [RL5] prescalers for /4, /12, /48
  for (genvar g = 0; g < 3; g++) begin : gDiv
    logic [5:0] cnt;
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt <= 6'h00;
      end else if (ce) begin
        cnt <= (cnt == 6'(DIVS[g] - 1)) ? 6'h00 : cnt + 6'h01;
      end
    end
    assign divTick[g] = (cnt == 6'(DIVS[g] - 1));
  end

  // external clock passes two flops, then its rising edges are divided by 8
  always_ff @(posedge clk) begin
    if (rst) begin
      extS1 <= 1'b0;
      extS2 <= 1'b0;
      extPrev <= 1'b0;
      extCnt <= 3'h0;
    end else if (ce) begin
      extS1 <= extOscClk;
      extS2 <= extS1;
      extPrev <= extS2;
      if (extS2 && !extPrev) begin
        extCnt <= extCnt + 3'h1;
      end
    end
  end
  assign extTick = extS2 && !extPrev && (extCnt == EXT_DIV_LAST);

  // [RL5] source select; unused codes stop the timer
  always_comb begin
    unique case (clkSel)
      CLK_SYS: tmrTick = 1'b1;
      CLK_DIV4: tmrTick = divTick[0];
      CLK_DIV12: tmrTick = divTick[1];
      CLK_DIV48: tmrTick = divTick[2];
      CLK_EXT8: tmrTick = extTick;
      default: tmrTick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit and receive timers
  logic [7:0] txTmr, rxTmr;
  logic txHalf, rxHalf;
  logic txOvf, rxOvf, txBaud, rxSample;
  logic startDet;

  assign txOvf = tmrEn && tmrTick && (txTmr == TMR_TOP);
  assign rxOvf = tmrEn && tmrTick && (rxTmr == TMR_TOP);
  // [RL3] every second overflow is a bit edge
  assign txBaud = txOvf && txHalf;
  assign rxSample = rxOvf && rxHalf;

  // [RL1] transmit timer, auto-reload on overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      txTmr <= 8'h00;
      txHalf <= 1'b0;
    end else if (ce && tmrEn && tmrTick) begin
      txTmr <= txOvf ? reloadVal : txTmr + 8'h01;
      txHalf <= txHalf ^ txOvf;
    end
  end

  // [RL2] rx copy of the timer runs with the same enable and reload
  always_ff @(posedge clk) begin
    if (rst) begin
      rxTmr <= 8'h00;
      rxHalf <= 1'b0;
    end else if (ce && startDet) begin
      // [RL4] start forces reload; first overflow lands mid start bit
      rxTmr <= reloadVal;
      rxHalf <= 1'b1;
    end else if (ce && tmrEn && tmrTick) begin
      rxTmr <= rxOvf ? reloadVal : rxTmr + 8'h01;
      rxHalf <= rxHalf ^ rxOvf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  logic [11:0] txShift; // idle slot, start, data, optional ninth, stop
  logic [3:0] txLeft; // bits still to send, zero when idle
  logic txLoad, txDoneSet;

  // [RL9] data buffer write starts a character
  assign txLoad = wrStrobe && wordIdx == DATA_IDX;
  // [RL10] flag when the stop bit appears on the line
  assign txDoneSet = ce && txBaud && txLeft == 4'h2;

  // a write while busy restarts the frame; software should wait for the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      txShift <= 12'hFFF;
      txLeft <= 4'h0;
    end else if (txLoad) begin
      // [RL7] [RL8] start, data lsb first, optional ninth, stop
      // idle slot first: the start bit waits for a bit edge, so the far end never sees it cut short
      txShift <= frame9 ? {1'b1, tx9, writedata[7:0], 2'b01} : {2'b11, writedata[7:0], 2'b01};
      txLeft <= (frame9 ? FRAME_BITS_9 : FRAME_BITS_8) + 4'h1;
    end else if (ce && txBaud && txLeft != 4'h0) begin
      txShift <= {1'b1, txShift[11:1]};
      txLeft <= txLeft - 4'h1;
    end
  end
  assign link.portToNode = txShift[0]; // idle shift content is all ones

  ////////////////////////////////////////////////////////////////////////
  // receiver
  typedef enum logic {RX_IDLE, RX_BITS} aspt_rx_t;
  aspt_rx_t rxState;
  logic rxS1, rxS2, rxPrev; // line synchroniser and edge memory
  logic [3:0] rxCnt; // samples taken in this frame
  logic [8:0] rxShift;
  logic lastSample, bit9, rxLoad;
  logic [7:0] rxByte;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxPrev <= 1'b1;
    end else if (ce) begin
      rxS1 <= link.nodeToPort;
      rxS2 <= rxS1;
      rxPrev <= rxS2;
    end
  end

  // [RL23] [RL11] falling edge while idle and enabled
  assign startDet = rxState == RX_IDLE && rxEn && rxPrev && !rxS2;
  assign lastSample = rxSample && rxCnt == ((frame9 ? FRAME_BITS_9 : FRAME_BITS_8) - 4'h1);
  // [RL13] ninth bit kept in 9-bit mode, stop bit otherwise
  assign bit9 = frame9 ? rxShift[8] : rxS2;
  assign rxByte = frame9 ? rxShift[7:0] : rxShift[8:1];
  // [RL11] [RL12] [RL13] [RL14] [RL15] load only if enabled, flag clear and qualifier met
  assign rxLoad = ce && rxEn && rxState == RX_BITS && lastSample && !rxDone && (!qual || bit9);

  always_ff @(posedge clk) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxCnt <= 4'h0;
      rxShift <= 9'h000;
    end else if (ce) begin
      unique case (rxState)
        RX_IDLE: begin
          rxCnt <= 4'h0;
          if (startDet) begin
            rxState <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (!rxEn) begin
            rxState <= RX_IDLE; // [RL11] disable aborts the frame
          end else if (rxSample) begin
            rxCnt <= rxCnt + 4'h1;
            if (rxCnt == 4'h0 && rxS2) begin
              rxState <= RX_IDLE; // glitch, start bit not low at mid-bit
            end else if (lastSample) begin
              rxState <= RX_IDLE;
            end else if (rxCnt != 4'h0) begin
              rxShift <= {rxS2, rxShift[8:1]};
            end
          end
        end
      endcase
    end
  end

  // receive latch changes only on an accepted frame
  always_ff @(posedge clk) begin
    if (rst) begin
      rxBuf <= 8'h00;
    end else if (rxLoad) begin
      rxBuf <= rxByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial_port_control; hardware sets beat software clears in the same cycle
  logic ctrlWr;
  assign ctrlWr = wrStrobe && wordIdx == CTRL_IDX;

  always_ff @(posedge clk) begin
    if (rst) begin
      frame9 <= CTRL_RESET[FRAME_BIT];
      qual <= CTRL_RESET[QUAL_BIT];
      rxEn <= CTRL_RESET[RXEN_BIT];
      tx9 <= CTRL_RESET[TX9_BIT];
      rx9 <= CTRL_RESET[RX9_BIT];
      txDone <= CTRL_RESET[TXDONE_BIT];
      rxDone <= CTRL_RESET[RXDONE_BIT];
    end else begin
      if (ctrlWr) begin
        // [RL6] frame width select
        frame9 <= writedata[FRAME_BIT];
        qual <= writedata[QUAL_BIT];
        rxEn <= writedata[RXEN_BIT];
        tx9 <= writedata[TX9_BIT];
      end
      if (rxLoad) begin
        rx9 <= bit9;
      end else if (ctrlWr) begin
        rx9 <= writedata[RX9_BIT];
      end
      // [RL17] flags cleared only by a software write
      if (txDoneSet) begin
        txDone <= 1'b1;
      end else if (ctrlWr) begin
        txDone <= writedata[TXDONE_BIT];
      end
      // [RL18] receive flag at stop sampling
      if (rxLoad) begin
        rxDone <= 1'b1;
      end else if (ctrlWr) begin
        rxDone <= writedata[RXDONE_BIT];
      end
    end
  end

endmodule

/* aspt_node.sv */
// far-end asynchronous serial node with fixed bit time
`timescale 1ns/1ps
module aspt_node
  import aspt_pkg::*;
#(
  parameter int CLKS_PER_BIT = NODE_CLKS_PER_BIT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic nineBit, // frame with ninth bit
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic txNinth, // [RL20] one for address, zero for data
  output logic rxValid, // one-cycle pulse per frame
  output logic [7:0] rxData,
  output logic rxNinth,
  output logic rxStop, // sampled stop bit
  aspt_link_if.node link
);

  localparam int CW = $clog2(CLKS_PER_BIT + 1);

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  logic [10:0] txShift;
  logic [3:0] txLeft;
  logic [CW-1:0] txTime;

  assign txReady = txLeft == 4'h0;

  // [RL7] [RL8] frame shifted lsb first, each bit held one bit time
  always_ff @(posedge clk) begin
    if (rst) begin
      txShift <= 11'h7FF;
      txLeft <= 4'h0;
      txTime <= '0;
    end else if (ce) begin
      if (txReady && txValid) begin
        txShift <= nineBit ? {1'b1, txNinth, txData, 1'b0} : {2'b11, txData, 1'b0};
        txLeft <= nineBit ? FRAME_BITS_9 : FRAME_BITS_8;
        txTime <= CW'(CLKS_PER_BIT - 1);
      end else if (!txReady) begin
        if (txTime == '0) begin
          txShift <= {1'b1, txShift[10:1]};
          txLeft <= txLeft - 4'h1;
          txTime <= CW'(CLKS_PER_BIT - 1);
        end else begin
          txTime <= txTime - CW'(1);
        end
      end
    end
  end
  assign link.nodeToPort = txShift[0];

  ////////////////////////////////////////////////////////////////////////
  // receiver
  logic rxS1, rxS2, rxPrev;
  logic rxBusy;
  logic [3:0] rxCnt;
  logic [CW-1:0] rxTime;
  logic [8:0] rxShift;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxPrev <= 1'b1;
    end else if (ce) begin
      rxS1 <= link.portToNode;
      rxS2 <= rxS1;
      rxPrev <= rxS2;
    end
  end

  // sample at mid-bit, starting half a bit after the falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      rxBusy <= 1'b0;
      rxCnt <= 4'h0;
      rxTime <= '0;
      rxShift <= 9'h000;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxNinth <= 1'b0;
      rxStop <= 1'b0;
    end else if (ce) begin
      rxValid <= 1'b0;
      if (!rxBusy) begin
        if (rxPrev && !rxS2) begin
          rxBusy <= 1'b1;
          rxCnt <= 4'h0;
          rxTime <= CW'(CLKS_PER_BIT / 2);
        end
      end else if (rxTime != '0) begin
        rxTime <= rxTime - CW'(1);
      end else begin
        rxTime <= CW'(CLKS_PER_BIT - 1);
        rxCnt <= rxCnt + 4'h1;
        if (rxCnt == 4'h0 && rxS2) begin
          rxBusy <= 1'b0; // false start
        end else if (rxCnt == (nineBit ? FRAME_BITS_9 : FRAME_BITS_8) - 4'h1) begin
          rxBusy <= 1'b0;
          rxValid <= 1'b1;
          rxData <= nineBit ? rxShift[7:0] : rxShift[8:1];
          rxNinth <= nineBit ? rxShift[8] : rxS2;
          rxStop <= rxS2;
        end else if (rxCnt != 4'h0) begin
          rxShift <= {rxS2, rxShift[8:1]};
        end
      end
    end
  end

endmodule

/* aspt_chk.sv */
// bus and serial-link assertions for the port and its far-end node
`timescale 1ns/1ps
module aspt_chk
  import aspt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic [9:0] address,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic portToNode,
  input wire logic nodeToPort,
  input wire logic txValid,
  input wire logic txReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // one wait cycle, then the answer
  sequence s_waitThenAck;
    waitrequest ##1 !waitrequest;
  endsequence
  // node line drops to a start bit soon after a frame is taken
  sequence s_nodeStart;
    ##[1:3] !nodeToPort;
  endsequence
  a_bus_one_wait: assert property ($rose(read || write) |-> s_waitThenAck)
    else $error("bus request not answered after one wait cycle");
  a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read data upper lanes not zero");
  // a data write loads an idle slot, so the line is high until the next bit edge
  a_tx_write_starts: assert property (write && !waitrequest && address[9:2] == DATA_IDX |=> portToNode)
    else $error("data write did not hold the line idle before the start bit");
  // any high bit lasts at least eight clocks; a restarted frame may cut a low bit short, so only rises count
  a_port_bit_len: assert property ($rose(portToNode) |-> portToNode [*8])
    else $error("port high bit shorter than eight clocks");
  a_node_bit_len: assert property ($fell(nodeToPort) |-> !nodeToPort [*8])
    else $error("node low bit shorter than eight clocks");
  a_node_start: assert property (txValid && txReady |-> s_nodeStart)
    else $error("node did not send a start bit");
  a_node_busy: assert property (txValid && txReady |=> !txReady [*8])
    else $error("node ready again inside a frame");
endmodule

/* aspt_port_tb.sv */
// self-checking bench: port and far-end node joined over the serial link
`timescale 1ns/1ps
module aspt_port_tb;
  import aspt_pkg::*;
  localparam int LIMIT = 50000; // frames plus the slow clock-source sweep
  logic clk, rst, ce, extOscClk, read, write, waitrequest, irq;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic nineBit, txValid, txReady, txNinth, rxValid, rxNinth, rxStop;
  logic [7:0] txData, rxData, rd;
  int failures, n_checks, cyc, n;
  logic [2:0] srcs [5] = '{CLK_SYS, CLK_DIV4, CLK_DIV12, CLK_DIV48, CLK_EXT8};
  int divs [5] = '{1, DIV4, DIV12, DIV48, 16}; // ext/8 of a 40 ns clock is 16 clocks
  aspt_link_if aspt_link_if_i ();
  aspt_port aspt_port_i (.clk(clk), .rst(rst), .ce(ce), .extOscClk(extOscClk), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .link(aspt_link_if_i.port));
  aspt_node aspt_node_i (.clk(clk), .rst(rst), .ce(ce), .nineBit(nineBit), .txValid(txValid), .txReady(txReady),
    .txData(txData), .txNinth(txNinth), .rxValid(rxValid), .rxData(rxData), .rxNinth(rxNinth), .rxStop(rxStop),
    .link(aspt_link_if_i.node));
  aspt_chk aspt_chk_i (.clk(clk), .rst(rst), .read(read), .write(write), .address(address), .readdata(readdata),
    .waitrequest(waitrequest), .portToNode(aspt_link_if_i.portToNode), .nodeToPort(aspt_link_if_i.nodeToPort),
    .txValid(txValid), .txReady(txReady));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // offset so external edges never meet system edges
  initial begin
    extOscClk = 1'b0;
    #3;
    forever #20 extOscClk = ~extOscClk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkInt(input string name, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  // no limit of its own: the hang guard ends a stuck access
  task automatic busAcc(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h00_0000, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    busAcc(1'b1, idx, d, q);
  endtask
  task automatic rdChk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    busAcc(1'b0, idx, 8'h00, rd);
    chk(name, exp, rd);
  endtask
  // idle node is ready, so the frame is taken at the first edge
  task automatic nodeSend(input logic [7:0] d, input logic ninth);
    int k;
    k = 0;
    @(posedge clk);
    txData <= d;
    txNinth <= ninth;
    txValid <= 1'b1;
    @(posedge clk);
    txValid <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (txReady !== 1'b1 && k < 2000);
    repeat (10) @(posedge clk);
  endtask
  task automatic waitRx();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rxValid !== 1'b1 && k < 2000);
  endtask
  task automatic waitLine(input logic lvl);
    n = 0;
    while (aspt_link_if_i.portToNode !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      results();
    end
  end
  initial begin
    cyc = 0;
    failures = 0;
    n_checks = 0;
    {ce, rst, read, write, nineBit, txValid, txNinth} = 7'b110_0000;
    address = '0;
    writedata = '0;
    txData = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk("control reset", CTRL_IDX, CTRL_RESET);
    rdChk("reload reset", RELOAD_IDX, RELOAD_RESET);
    rdChk("unmapped", 8'h10, 8'h00);
    wr(CTRL_IDX, 8'h00);
    rdChk("unused bit", CTRL_IDX, 8'h40);
    wr(RELOAD_IDX, 8'hF3);
    wr(TCTRL_IDX, 8'h03);
    rdChk("timer control", TCTRL_IDX, 8'h03);
    wr(CTRL_IDX, 8'h10);
    $display("test registers done");
    wr(DATA_IDX, 8'hA5);
    // freeze both ends mid-frame; the character must survive the pause
    repeat (60) @(posedge clk);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    waitRx();
    chk("node data", 8'hA5, rxData);
    chk("node stop", 8'h01, {7'h00, rxStop});
    rdChk("tx flag", CTRL_IDX, 8'h52);
    chk("irq tx", 8'h01, {7'h00, irq});
    wr(CTRL_IDX, 8'h10);
    rdChk("flags cleared", CTRL_IDX, 8'h50);
    chk("irq off", 8'h00, {7'h00, irq});
    $display("test transmit 8 done");
    nodeSend(8'h3C, 1'b0);
    rdChk("rx flag", CTRL_IDX, 8'h55);
    rdChk("rx data", DATA_IDX, 8'h3C);
    chk("irq rx", 8'h01, {7'h00, irq});
    nodeSend(8'hC3, 1'b0);
    rdChk("overrun data", DATA_IDX, 8'h3C);
    rdChk("overrun flags", CTRL_IDX, 8'h55);
    wr(CTRL_IDX, 8'h00);
    nodeSend(8'h11, 1'b0);
    rdChk("rx off flags", CTRL_IDX, 8'h40);
    rdChk("rx off data", DATA_IDX, 8'h3C);
    $display("test receive 8 done");
    nineBit <= 1'b1;
    wr(CTRL_IDX, 8'hB0);
    nodeSend(8'h22, 1'b0);
    rdChk("qualified reject", CTRL_IDX, 8'hF0);
    nodeSend(8'h44, 1'b1);
    rdChk("qualified accept", CTRL_IDX, 8'hF5);
    rdChk("address byte", DATA_IDX, 8'h44);
    wr(CTRL_IDX, 8'h98);
    wr(DATA_IDX, 8'h5A);
    waitRx();
    chk("node ninth", 8'h01, {7'h00, rxNinth});
    chk("node data 9", 8'h5A, rxData);
    rdChk("tx flag 9", CTRL_IDX, 8'hDA);
    $display("test nine bit done");
    // alternating bits give a clean high data bit to time
    wr(CTRL_IDX, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(TCTRL_IDX, {1'b0, srcs[i], 4'h3});
      wr(DATA_IDX, 8'h55);
      waitLine(1'b0);
      waitLine(1'b1);
      chkInt("start time", 2 * (256 - 8'hF3) * divs[i], n);
      waitLine(1'b0);
      chkInt("bit time", 2 * (256 - 8'hF3) * divs[i], n);
      repeat (12 * 26 * divs[i]) @(posedge clk);
    end
    $display("test clock sources done");
    results();
  end
endmodule
